// >>> pkg/cipd_pkg.sv
package cipd_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned BIAS_DELAY_MS = 220;
    localparam int unsigned RETRY_MS = 2000;
    localparam int unsigned DCD_MS = 500;
    localparam int unsigned LOAD_MS = 30;
    localparam int unsigned BIAS_DELAY_CYC = CLK_HZ / 1000 * BIAS_DELAY_MS;
    localparam int unsigned RETRY_CYC = CLK_HZ / 1000 * RETRY_MS;
    localparam int unsigned DCD_CYC = CLK_HZ / 1000 * DCD_MS;
    localparam int unsigned LOAD_CYC = CLK_HZ / 1000 * LOAD_MS;
    localparam int unsigned INT_PULSE_CYC = 16;
    // Avalon register offsets (byte addresses)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_LIMIT = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_APPLIED = 4'hc;
    // Control bits
    localparam int unsigned CTRL_AUTO = 0;
    localparam int unsigned CTRL_HVA = 1;
    localparam int unsigned CTRL_HVB = 2;
    localparam int unsigned CTRL_FORCE = 3;
    localparam int unsigned CTRL_SHIP_EXIT = 4;
    localparam logic [4:0] CTRL_RESET = 5'h07;
    // Current limit codes, 100 mA plus 50 mA per step
    localparam logic [5:0] LIM_500MA = 6'h08;
    localparam logic [5:0] LIM_1A = 6'h12;
    localparam logic [5:0] LIM_1P5A = 6'h1c;
    localparam logic [5:0] LIM_2A = 6'h26;
    localparam logic [5:0] LIM_2P1A = 6'h28;
    localparam logic [5:0] LIM_2P4A = 6'h2e;
    localparam logic [5:0] LIM_3P25A = 6'h3f;
    localparam logic [5:0] LIM_RESET = 6'h08;
    // Port type codes
    localparam logic [2:0] PT_NONE = 3'h0;
    localparam logic [2:0] PT_SDP = 3'h1;
    localparam logic [2:0] PT_CDP = 3'h2;
    localparam logic [2:0] PT_DCP = 3'h3;
    localparam logic [2:0] PT_HV = 3'h4;
    localparam logic [2:0] PT_UNKNOWN = 3'h5;
    localparam logic [2:0] PT_DIVIDER = 3'h6;
    // BC1.2 result codes from the port front end
    localparam logic [1:0] BC_SDP = 2'h1;
    localparam logic [1:0] BC_CDP = 2'h2;
    localparam logic [1:0] BC_DCP = 2'h3;

    typedef enum logic [2:0] {
        CIPD_HIZ = 3'b000,
        CIPD_QUAL = 3'b001,
        CIPD_WAIT = 3'b011,
        CIPD_DETECT = 3'b010,
        CIPD_HANDSHAKE = 3'b110,
        CIPD_RUN = 3'b111
    } cipd_state_e;

    typedef struct packed {
        logic input_uvlo_ok;
        logic sleep_ok;
        logic below_ovp;
        logic above_min;
        logic batt_above_dplz;
        logic discharge_oc;
    } cipd_cmp_s;

    typedef struct packed {
        logic dp_1p2;
        logic dp_2p0;
        logic dp_2p7;
        logic dm_1p2;
        logic dm_2p0;
        logic dm_2p7;
    } cipd_win_s;

    typedef struct packed {
        logic dp_sink;
        logic dp_source;
        logic dm_sink;
        logic dm_source;
    } cipd_drive_s;
endpackage : cipd_pkg

// >>> design/cipd_sequencer.sv
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module cipd_sequencer import cipd_pkg::*; #(
    parameter int unsigned BIAS_CYC = BIAS_DELAY_CYC,
    parameter int unsigned RETRY_WAIT_CYC = RETRY_CYC,
    parameter int unsigned DCD_WAIT_CYC = DCD_CYC,
    parameter int unsigned LOAD_WAIT_CYC = LOAD_CYC,
    parameter int unsigned PULSE_CYC = INT_PULSE_CYC,
    parameter bit HV_12V = 1'b1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Analog comparators
    input wire cipd_cmp_s cmp_in,
    input wire logic boost_mode,
    input wire logic [5:0] limit_pin,
    // Port detection front end
    input wire logic bc_done,
    input wire logic [1:0] bc_result,
    input wire cipd_win_s win_in,
    // Power controls
    output logic battery_switch_ff,
    output logic bias_regulator_ff,
    output logic high_impedance_state_ff,
    output logic load_enable_ff,
    output logic bc_start_ff,
    output cipd_drive_s drive_ff,
    output logic converter_enable_ff,
    output logic [5:0] applied_limit_ff,
    // Host interrupt
    output logic host_int_n_ff
);
    cipd_state_e state_ff, nxt_state;
    cipd_cmp_s cmp_meta_ff, cmp_ff;
    cipd_win_s win_meta_ff, win_ff;
    logic bc_done_meta_ff, bc_done_ff;
    logic [1:0] bc_res_meta_ff, bc_res_ff;
    logic [31:0] timer_ff;
    logic [7:0] pulse_ff;
    logic [4:0] ctrl_ff;
    logic [5:0] input_current_limit_ff;
    logic [2:0] port_type_status_ff;
    logic [1:0] source_type_status_ff;
    logic input_good_flag_ff, power_good_flag_ff, battery_switch_disabled_ff;
    logic ack_ff, int_pend_ff;
    logic int_req, det_done, hv_en, wr_ok, rd_ok, attached;
    logic [5:0] det_limit;
    logic [2:0] det_type;

    assign attached = cmp_ff.input_uvlo_ok;
    assign hv_en = ctrl_ff[CTRL_HVA] | ctrl_ff[CTRL_HVB];
    assign wr_ok = avs_write & ack_ff;
    assign rd_ok = avs_read & ~ack_ff;

    // Comparator and port front end synchronisers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cmp_meta_ff <= '0;
            cmp_ff <= '0;
            win_meta_ff <= '0;
            win_ff <= '0;
            bc_done_meta_ff <= 1'b0;
            bc_done_ff <= 1'b0;
            bc_res_meta_ff <= 2'h0;
            bc_res_ff <= 2'h0;
        end else begin
            cmp_meta_ff <= cmp_in;
            cmp_ff <= cmp_meta_ff;
            win_meta_ff <= win_in;
            win_ff <= win_meta_ff;
            bc_done_meta_ff <= bc_done;
            bc_done_ff <= bc_done_meta_ff;
            bc_res_meta_ff <= bc_result;
            bc_res_ff <= bc_res_meta_ff;
        end
    end

    // Divider adapter decode
    always_comb begin
        det_limit = LIM_500MA;
        det_type = PT_UNKNOWN;
        if (win_ff.dp_2p7 && win_ff.dm_2p0) begin
            det_limit = LIM_2P1A;
            det_type = PT_DIVIDER;
        end else if (win_ff.dp_1p2 && win_ff.dm_1p2) begin
            det_limit = LIM_2A;
            det_type = PT_DIVIDER;
        end else if (win_ff.dp_2p0 && win_ff.dm_2p7) begin
            det_limit = LIM_1A;
            det_type = PT_DIVIDER;
        end else if (win_ff.dp_2p7 && win_ff.dm_2p7) begin
            det_limit = LIM_2P4A;
            det_type = PT_DIVIDER;
        end
    end

    // Sequencer
    always_comb begin
        nxt_state = state_ff;
        det_done = 1'b0;
        case (state_ff)
            CIPD_HIZ: begin
                if (attached && cmp_ff.sleep_ok && timer_ff >= BIAS_CYC - 1) begin
                    nxt_state = CIPD_QUAL;
                end
            end
            CIPD_QUAL: begin
                if (timer_ff >= LOAD_WAIT_CYC - 1) begin
                    if (cmp_ff.below_ovp && cmp_ff.above_min) begin
                        nxt_state = (ctrl_ff[CTRL_AUTO] || ctrl_ff[CTRL_FORCE]) ? CIPD_DETECT : CIPD_RUN;
                    end else begin
                        nxt_state = CIPD_WAIT;
                    end
                end
            end
            CIPD_WAIT: begin
                if (timer_ff >= RETRY_WAIT_CYC - 1) begin
                    nxt_state = CIPD_QUAL;
                end
            end
            CIPD_DETECT: begin
                if (bc_done_ff) begin
                    if (bc_res_ff == BC_DCP && hv_en) begin
                        nxt_state = CIPD_HANDSHAKE;
                    end else begin
                        nxt_state = CIPD_RUN;
                        det_done = 1'b1;
                    end
                end else if (timer_ff >= DCD_WAIT_CYC - 1) begin
                    nxt_state = CIPD_RUN;
                    det_done = 1'b1;
                end
            end
            CIPD_HANDSHAKE: begin
                if (timer_ff >= LOAD_WAIT_CYC - 1) begin
                    nxt_state = CIPD_RUN;
                    det_done = 1'b1;
                end
            end
            CIPD_RUN: begin
                if (ctrl_ff[CTRL_FORCE]) begin
                    nxt_state = CIPD_DETECT;
                end
            end
            default: nxt_state = CIPD_HIZ;
        endcase
        if (!attached || !cmp_ff.sleep_ok) begin
            nxt_state = CIPD_HIZ;
            det_done = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= CIPD_HIZ;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Delay timer restarts on each state change
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            timer_ff <= 32'h0000_0000;
        end else if (nxt_state != state_ff || (state_ff == CIPD_HIZ && !(attached && cmp_ff.sleep_ok))) begin
            timer_ff <= 32'h0000_0000;
        end else if (timer_ff != 32'hffff_ffff) begin
            timer_ff <= timer_ff + 32'h0000_0001;
        end
    end

    // Power outputs
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bias_regulator_ff <= 1'b0;
            high_impedance_state_ff <= 1'b1;
            load_enable_ff <= 1'b0;
            bc_start_ff <= 1'b0;
            drive_ff <= '0;
            converter_enable_ff <= 1'b0;
        end else begin
            bias_regulator_ff <= nxt_state != CIPD_HIZ;
            high_impedance_state_ff <= nxt_state == CIPD_HIZ;
            load_enable_ff <= nxt_state == CIPD_QUAL;
            bc_start_ff <= nxt_state == CIPD_DETECT;
            drive_ff.dp_sink <= nxt_state == CIPD_HANDSHAKE && HV_12V;
            drive_ff.dm_source <= nxt_state == CIPD_HANDSHAKE && HV_12V;
            drive_ff.dp_source <= nxt_state == CIPD_HANDSHAKE && !HV_12V;
            drive_ff.dm_sink <= nxt_state == CIPD_HANDSHAKE && !HV_12V;
            converter_enable_ff <= nxt_state == CIPD_RUN;
        end
    end

    // Battery switch and overcurrent latch
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            battery_switch_ff <= 1'b0;
            battery_switch_disabled_ff <= 1'b0;
        end else begin
            if (cmp_ff.discharge_oc) begin
                battery_switch_disabled_ff <= 1'b1;
            end else if ((attached && !cmp_ff.sleep_ok) || state_ff == CIPD_QUAL || ctrl_ff[CTRL_SHIP_EXIT]) begin
                battery_switch_disabled_ff <= 1'b0;
            end
            battery_switch_ff <= cmp_ff.batt_above_dplz && !cmp_ff.discharge_oc
                && !battery_switch_disabled_ff;
        end
    end

    // Status flags and detection results
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            input_good_flag_ff <= 1'b0;
            power_good_flag_ff <= 1'b0;
            input_current_limit_ff <= LIM_RESET;
            port_type_status_ff <= PT_NONE;
            source_type_status_ff <= 2'h0;
        end else begin
            if (nxt_state == CIPD_HIZ) begin
                input_good_flag_ff <= 1'b0;
                power_good_flag_ff <= 1'b0;
            end else if (state_ff == CIPD_QUAL && nxt_state != CIPD_WAIT && nxt_state != CIPD_QUAL) begin
                input_good_flag_ff <= 1'b1;
                if (nxt_state == CIPD_RUN) begin
                    power_good_flag_ff <= 1'b1;
                end
            end
            if (det_done) begin
                power_good_flag_ff <= 1'b1;
                source_type_status_ff <= bc_done_ff ? bc_res_ff : 2'h0;
                if (state_ff == CIPD_HANDSHAKE) begin
                    input_current_limit_ff <= LIM_1P5A;
                    port_type_status_ff <= PT_HV;
                end else if (!bc_done_ff) begin
                    input_current_limit_ff <= det_limit;
                    port_type_status_ff <= det_type;
                end else if (bc_res_ff == BC_CDP) begin
                    input_current_limit_ff <= LIM_1P5A;
                    port_type_status_ff <= PT_CDP;
                end else if (bc_res_ff == BC_DCP) begin
                    input_current_limit_ff <= LIM_3P25A;
                    port_type_status_ff <= PT_DCP;
                end else begin
                    input_current_limit_ff <= LIM_500MA;
                    port_type_status_ff <= PT_SDP;
                end
            end else if (wr_ok && avs_address == ADDR_LIMIT && avs_byteenable[0]) begin
                input_current_limit_ff <= avs_writedata[5:0];
            end
        end
    end

    // Applied limit
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            applied_limit_ff <= LIM_RESET;
        end else begin
            applied_limit_ff <= (limit_pin < input_current_limit_ff) ? limit_pin : input_current_limit_ff;
        end
    end

    // Control register with self-clearing force bit
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff <= CTRL_RESET;
        end else begin
            if (wr_ok && avs_address == ADDR_CTRL && avs_byteenable[0]) begin
                ctrl_ff <= avs_writedata[4:0];
            end else begin
                ctrl_ff[CTRL_SHIP_EXIT] <= 1'b0;
            end
            if (det_done) begin
                ctrl_ff[CTRL_FORCE] <= 1'b0;
            end
        end
    end

    // Interrupt pulse, a request during a pulse waits for the gap
    assign int_req = det_done || (state_ff == CIPD_QUAL && nxt_state != CIPD_WAIT
        && nxt_state != CIPD_QUAL && nxt_state != CIPD_HIZ);
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pulse_ff <= 8'h00;
            int_pend_ff <= 1'b0;
            host_int_n_ff <= 1'b1;
        end else begin
            if ((int_req || int_pend_ff) && pulse_ff == 8'h00) begin
                pulse_ff <= 8'(PULSE_CYC);
                int_pend_ff <= 1'b0;
            end else begin
                if (int_req) begin
                    int_pend_ff <= 1'b1;
                end
                if (pulse_ff != 8'h00) begin
                    pulse_ff <= pulse_ff - 8'h01;
                end
            end
            host_int_n_ff <= !(((int_req || int_pend_ff) && pulse_ff == 8'h00) || pulse_ff > 8'h01);
        end
    end

    // Avalon-MM slave, one wait state
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ack_ff <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_ff <= (avs_read || avs_write) && !ack_ff;
            if (rd_ok) begin
                case (avs_address)
                    ADDR_CTRL: avs_readdata <= {27'h0, ctrl_ff};
                    ADDR_LIMIT: avs_readdata <= {26'h0, input_current_limit_ff};
                    ADDR_STATUS: avs_readdata <= {24'h0, battery_switch_disabled_ff, power_good_flag_ff,
                        input_good_flag_ff, source_type_status_ff, port_type_status_ff};
                    ADDR_APPLIED: avs_readdata <= {21'h0, state_ff, 2'h0, applied_limit_ff};
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
endmodule : cipd_sequencer
`default_nettype wire

// >>> bench/cipd_sequencer_properties.sv
`timescale 1ns/1ns
`default_nettype none
module cipd_sequencer_properties import cipd_pkg::*; #(
    parameter int unsigned BIAS_CYC = 20,
    parameter int unsigned PULSE_CYC = 16,
    parameter bit HV_12V = 1'b1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Inputs watched
    input wire cipd_cmp_s cmp_in,
    input wire logic [5:0] limit_pin,
    // Outputs watched
    input wire logic battery_switch_ff,
    input wire logic bias_regulator_ff,
    input wire logic high_impedance_state_ff,
    input wire logic load_enable_ff,
    input wire cipd_drive_s drive_ff,
    input wire logic converter_enable_ff,
    input wire logic [5:0] applied_limit_ff,
    input wire logic host_int_n_ff
);
    int unsigned up_cnt;
    int unsigned low_cnt;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            up_cnt <= 0;
        end else begin
            up_cnt <= (cmp_in.input_uvlo_ok && cmp_in.sleep_ok) ? up_cnt + 1 : 0;
        end
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            low_cnt <= 0;
        end else begin
            low_cnt <= host_int_n_ff ? 0 : low_cnt + 1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Bus request and its one-cycle answer
    sequence s_req;
        $rose(avs_read || avs_write);
    endsequence
    sequence s_ans;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    AST_BUS_ANSWER: assert property (s_req |-> s_ans)
        else $error("bus answer not in second cycle");
    AST_HIZ_DROP: assert property ((!cmp_in.input_uvlo_ok) [*6] |-> !bias_regulator_ff && high_impedance_state_ff)
        else $error("bias on without input");
    AST_BIAS_DELAY: assert property ($rose(bias_regulator_ff) |-> up_cnt >= BIAS_CYC)
        else $error("bias on before delay");
    AST_INT_WIDTH: assert property ($rose(host_int_n_ff) |-> low_cnt == PULSE_CYC)
        else $error("interrupt pulse width wrong");
    AST_CONV_ORDER: assert property (converter_enable_ff |-> bias_regulator_ff && !(|drive_ff))
        else $error("converter on too early");
    AST_DRIVE_ROLES: assert property (|drive_ff |-> drive_ff == (HV_12V ? 4'h9 : 4'h6))
        else $error("handshake drive roles wrong");
    AST_DRIVE_BIAS: assert property (|drive_ff |-> bias_regulator_ff)
        else $error("handshake without bias");
    AST_OC_OFF: assert property (cmp_in.discharge_oc [*5] |-> !battery_switch_ff)
        else $error("battery switch on under overcurrent");
    AST_APPLIED_MIN: assert property ($stable(limit_pin) [*4] |-> applied_limit_ff <= limit_pin)
        else $error("applied limit above pin");
    AST_LOAD_BIAS: assert property (load_enable_ff |-> bias_regulator_ff)
        else $error("test load without bias");
endmodule : cipd_sequencer_properties
`default_nettype wire

// >>> bench/cipd_port_model.sv
`timescale 1ns/1ns
`default_nettype none
module cipd_port_model import cipd_pkg::*; (
    // Clock
    input wire logic clock,
    // Scenario
    input wire logic [2:0] mode,
    input wire logic [5:0] delay,
    // Front end
    input wire logic bc_start_ff,
    input wire cipd_drive_s drive_ff,
    output logic bc_done,
    output logic [1:0] bc_result,
    output cipd_win_s win_in,
    output logic hv_seen
);
    logic [5:0] cnt;
    logic prev;
    initial begin
        cnt = 6'h00;
        prev = 1'b0;
        bc_done = 1'b0;
        bc_result = 2'h0;
        hv_seen = 1'b0;
    end
    // Modes 1..3 answer after delay, others never answer
    always @(posedge clock) begin
        prev <= bc_start_ff;
        if (!bc_start_ff || !prev) begin
            cnt <= 6'h00;
            bc_done <= 1'b0;
        end else if (cnt != delay) begin
            cnt <= cnt + 6'h01;
        end else if (mode inside {3'h1, 3'h2, 3'h3}) begin
            bc_done <= 1'b1;
        end
        bc_result <= (cnt == delay) ? mode[1:0] : ~bc_result;
        if (bc_start_ff && !prev) begin
            hv_seen <= 1'b0;
        end else if (|drive_ff) begin
            hv_seen <= 1'b1;
        end
    end
    // Divider windows for modes 4..7
    always_comb begin
        win_in = '0;
        case (mode)
            3'h4: win_in = '{dp_2p7: 1'b1, dm_2p0: 1'b1, default: 1'b0};
            3'h5: win_in = '{dp_1p2: 1'b1, dm_1p2: 1'b1, default: 1'b0};
            3'h6: win_in = '{dp_2p0: 1'b1, dm_2p7: 1'b1, default: 1'b0};
            3'h7: win_in = '{dp_2p7: 1'b1, dm_2p7: 1'b1, default: 1'b0};
            default: win_in = '0;
        endcase
    end
endmodule : cipd_port_model
`default_nettype wire

// >>> bench/cipd_sequencer_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(s, e, g) check(s, e, g)
module cipd_sequencer_bench import cipd_pkg::*;;
    logic clock, reset_n, read, write, waitreq, conv, high_impedance_state, bias, bsw, int_n, hv_seen, bc_done, bc_start, boost;
    logic [3:0] address, be;
    logic [31:0] wdata, rdata, q;
    logic [5:0] pin, applied, dly;
    logic [1:0] bc_result;
    logic [2:0] mode;
    cipd_cmp_s cmp;
    cipd_win_s win;
    cipd_drive_s drive;
    int fails, checks_done, ints, i0;
    logic [2:0] t_mode [10] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
    logic [4:0] t_ctrl [10] = '{5'h07, 5'h07, 5'h01, 5'h03, 5'h05, 5'h01, 5'h01, 5'h01, 5'h01, 5'h01};
    logic [2:0] t_pt [10] = '{PT_SDP, PT_CDP, PT_DCP, PT_HV, PT_HV, PT_DIVIDER, PT_DIVIDER, PT_DIVIDER,
        PT_DIVIDER, PT_UNKNOWN};
    logic [5:0] t_lim [10] = '{LIM_500MA, LIM_1P5A, LIM_3P25A, LIM_1P5A, LIM_1P5A, LIM_2P1A, LIM_2A, LIM_1A,
        LIM_2P4A, LIM_500MA};
    cipd_sequencer #(.BIAS_CYC(20), .RETRY_WAIT_CYC(50), .DCD_WAIT_CYC(40), .LOAD_WAIT_CYC(10),
        .PULSE_CYC(16)) i_dut (.clock(clock), .reset_n(reset_n), .avs_address(address),
        .avs_read(read), .avs_write(write), .avs_writedata(wdata), .avs_byteenable(be),
        .avs_readdata(rdata), .avs_waitrequest(waitreq), .cmp_in(cmp), .boost_mode(boost),
        .limit_pin(pin), .bc_done(bc_done), .bc_result(bc_result), .win_in(win),
        .battery_switch_ff(bsw), .bias_regulator_ff(bias), .high_impedance_state_ff(high_impedance_state),
        .load_enable_ff(), .bc_start_ff(bc_start), .drive_ff(drive), .converter_enable_ff(conv),
        .applied_limit_ff(applied), .host_int_n_ff(int_n));
    cipd_port_model i_port (.clock(clock), .mode(mode), .delay(dly), .bc_start_ff(bc_start),
        .drive_ff(drive), .bc_done(bc_done), .bc_result(bc_result), .win_in(win), .hv_seen(hv_seen));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(negedge int_n) begin
        ints++;
    end
    task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask : check
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        wdata <= d;
        read <= !w;
        write <= w;
        do begin
            @(posedge clock);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        q = rdata;
        read <= 1'b0;
        write <= 1'b0;
        `CHK("bus answer", 32'h0000_0001, 32'(n < 50));
    endtask : bus
    task automatic attach();
        int n;
        n = 0;
        @(posedge clock);
        cmp <= '{input_uvlo_ok: 1'b1, sleep_ok: 1'b1, below_ovp: 1'b1, above_min: 1'b1, batt_above_dplz: 1'b1,
            discharge_oc: 1'b0};
        while (conv !== 1'b1 && n < 3000) begin
            @(posedge clock);
            n++;
        end
        `CHK("converter on", 32'h0000_0001, 32'(conv));
    endtask : attach
    task automatic detach();
        @(posedge clock);
        cmp.input_uvlo_ok <= 1'b0;
        repeat (10) @(posedge clock);
        `CHK("hiz bias", 32'h0000_0002, {30'h0, high_impedance_state, bias});
    endtask : detach
    task automatic results();
        if (fails == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    initial begin
        #(40 * 20000);
        fails++;
        results();
    end
    initial begin
        {reset_n, read, write, address, wdata, cmp, fails, checks_done, ints} = '0;
        pin = 6'h3f;
        be = 4'hf;
        dly = 6'h03;
        boost = 1'b0;
        mode = 3'h1;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        bus(1'b0, ADDR_CTRL, 32'h0000_0000);
        `CHK("ctrl reset", 32'h0000_0007, q);
        bus(1'b0, ADDR_LIMIT, 32'h0000_0000);
        `CHK("limit reset", {26'h0, LIM_RESET}, q & 32'h0000_003f);
        bus(1'b0, 4'h2, 32'h0000_0000);
        `CHK("unmapped", 32'h0000_0000, q);
        cmp.batt_above_dplz <= 1'b1;
        repeat (8) @(posedge clock);
        `CHK("battery only", 32'h0000_0002, {30'h0, bsw, bias});
        cmp.discharge_oc <= 1'b1;
        repeat (8) @(posedge clock);
        cmp.discharge_oc <= 1'b0;
        repeat (8) @(posedge clock);
        `CHK("switch after oc", 32'h0000_0000, 32'(bsw));
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        `CHK("switch disabled", 32'h0000_0080, q & 32'h0000_0080);
        bus(1'b1, ADDR_CTRL, 32'h0000_0017);
        repeat (4) @(posedge clock);
        `CHK("ship exit", 32'h0000_0001, 32'(bsw));
        cmp <= '{input_uvlo_ok: 1'b1, sleep_ok: 1'b1, below_ovp: 1'b1, batt_above_dplz: 1'b1, default: 1'b0};
        repeat (30) @(posedge clock);
        `CHK("bias up", 32'h0000_0001, 32'(bias));
        repeat (60) @(posedge clock);
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        `CHK("qualify fail", 32'h0000_0000, {31'h0, conv} | (q & 32'h0000_0020));
        i0 = ints;
        attach();
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        `CHK("status after pass", 32'h0000_0061, q & 32'h0000_00e7);
        repeat (20) @(posedge clock);
        `CHK("interrupts", 32'h0000_0002, 32'(ints - i0));
        for (int i = 0; i < 10; i++) begin
            detach();
            bus(1'b1, ADDR_CTRL, {27'h0, t_ctrl[i]});
            mode <= t_mode[i];
            attach();
            bus(1'b0, ADDR_STATUS, 32'h0000_0000);
            `CHK("port type", {29'h0, t_pt[i]}, q & 32'h0000_0007);
            bus(1'b0, ADDR_LIMIT, 32'h0000_0000);
            `CHK("limit loaded", {26'h0, t_lim[i]}, q & 32'h0000_003f);
            `CHK("handshake", 32'(t_pt[i] == PT_HV), 32'(hv_seen));
            `CHK("applied", {26'h0, t_lim[i]}, {26'h0, applied});
        end
        bus(1'b1, ADDR_LIMIT, 32'h0000_0005);
        repeat (6) @(posedge clock);
        `CHK("applied reg", 32'h0000_0005, {26'h0, applied});
        pin <= 6'h03;
        repeat (6) @(posedge clock);
        bus(1'b0, ADDR_APPLIED, 32'h0000_0000);
        `CHK("applied pin", 32'h0000_0003, q & 32'h0000_003f);
        be <= 4'h0;
        bus(1'b1, ADDR_LIMIT, 32'h0000_0022);
        be <= 4'hf;
        bus(1'b0, ADDR_LIMIT, 32'h0000_0000);
        `CHK("masked write", 32'h0000_0005, q & 32'h0000_003f);
        bus(1'b1, ADDR_LIMIT, 32'h0000_0011);
        detach();
        bus(1'b1, ADDR_CTRL, 32'h0000_0000);
        mode <= 3'h2;
        i0 = ints;
        attach();
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        `CHK("skip status", 32'h0000_0065, q & 32'h0000_0067);
        bus(1'b0, ADDR_LIMIT, 32'h0000_0000);
        `CHK("skip limit", 32'h0000_0011, q & 32'h0000_003f);
        `CHK("skip interrupts", 32'h0000_0001, 32'(ints - i0));
        detach();
        bus(1'b1, ADDR_CTRL, 32'h0000_0008);
        attach();
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        `CHK("forced type", 32'h0000_0002, q & 32'h0000_0007);
        bus(1'b0, ADDR_CTRL, 32'h0000_0000);
        `CHK("force cleared", 32'h0000_0000, q & 32'h0000_0008);
        results();
    end
endmodule : cipd_sequencer_bench
bind cipd_sequencer cipd_sequencer_properties #(.BIAS_CYC(BIAS_CYC), .PULSE_CYC(PULSE_CYC), .HV_12V(HV_12V))
    i_props (.clock(clock), .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .cmp_in(cmp_in), .limit_pin(limit_pin),
    .battery_switch_ff(battery_switch_ff), .bias_regulator_ff(bias_regulator_ff),
    .high_impedance_state_ff(high_impedance_state_ff), .load_enable_ff(load_enable_ff), .drive_ff(drive_ff),
    .converter_enable_ff(converter_enable_ff), .applied_limit_ff(applied_limit_ff),
    .host_int_n_ff(host_int_n_ff));
`default_nettype wire
